// ===== iox_expander.sv
// Eight-bit serial-bus port expander with change alert
`timescale 1ns/1ps

// Contract
// [RULE_01] Reset initialises registers and bus machine
// [RULE_02] After reset all pins are inputs
// [RULE_03] Input pin: both drivers off
// [RULE_04] Output pin driven from output register
// [RULE_05] Input edge asserts alert within valid delay
// [RULE_06] Alert clears on revert or port read
// [RULE_07] Read clear at rising edge of ack
// [RULE_08] Change during ack pulse may be lost
// [RULE_09] Changes after a clear alert again
// [RULE_10] Foreign traffic and outputs never alert
// [RULE_11] Output-to-input switch alerts on mismatch
// [RULE_12] Alert is open drain, low when active
// [RULE_13] Pointer 00h: foreign read ack clears alert
// [RULE_14] Master rewrites pointer to avoid defect
// [RULE_15] Master starts only on idle bus
// [RULE_16] Address byte sent MSB first, direction last
// [RULE_17] Address is 0100 plus select pins
// [RULE_18] Matching address acknowledged low during ack
// [RULE_19] Select pins stable between start and stop
// [RULE_20] SDA change while SCL high is start/stop
// [RULE_21] Eight bits then ack, transmitter releases
// [RULE_22] Ack every written byte, stop on nack
// [RULE_23] Direction bit one reads, zero writes
// [RULE_24] First write byte sets sticky register pointer
// [RULE_25] Polarity bit inverts input value
// [RULE_26] Direction one is input; resets to ones
// [RULE_27] Synced pins compared with last read value
module iox_expander (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclClk,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addrSelectBit0,
  input wire logic addrSelectBit1,
  input wire logic addrSelectBit2,
  input wire logic [7:0] portPinsIn,
  output iox_pkg::iox_drive_t portPinsDrive,
  output iox_pkg::iox_side_t portDrivers,
  output logic changeAlertNOut,
  output logic changeAlertNOe
);
  import iox_pkg::*;

  localparam int AlertBound = IOX_ALERT_VALID_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: SDA is sampled at the true SCL rising edge

  logic [7:0] sclShiftQ;

  always_ff @(posedge sclClk) begin
    sclShiftQ <= {sclShiftQ[6:0], sdaIn};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [12:0] meta1Q;
  logic [12:0] syncQ;
  logic sclPrevQ;
  logic sdaPrevQ;
  logic sclS;
  logic sdaS;
  logic [2:0] addrS;
  logic [7:0] pinS;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta1Q <= '1;
      syncQ <= '1;
    end else begin
      meta1Q <= {sclIn, sdaIn, addrSelectBit2, addrSelectBit1, addrSelectBit0, portPinsIn};
      syncQ <= meta1Q;
    end
  end

  assign sclS = syncQ[12];
  assign sdaS = syncQ[11];
  assign addrS = syncQ[10:8];
  assign pinS = syncQ[7:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      sclPrevQ <= 1'b1;
      sdaPrevQ <= 1'b1;
    end else begin
      sclPrevQ <= sclS;
      sdaPrevQ <= sdaS;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus events

  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic byteDone;
  logic ackDone;
  logic addrMatch;
  logic [3:0] slotQ;
  logic [3:0] slotNext;
  iox_state_t stateQ;
  logic addrRwQ;
  logic ackNextQ;

  assign sclRise = sclS && !sclPrevQ;
  assign sclFall = !sclS && sclPrevQ;
  assign startCond = sclS && sclPrevQ && sdaPrevQ && !sdaS; // [RULE_20]
  assign stopCond = sclS && sclPrevQ && !sdaPrevQ && sdaS; // [RULE_20]
  // Shift register was updated at the real edge, well before the synced rise
  assign byteDone = sclRise && (slotQ == IOX_SLOT_LAST_DATA); // [RULE_21]
  assign ackDone = sclRise && (slotQ == IOX_SLOT_ACK);
  assign addrMatch = (sclShiftQ[7:1] == {IOX_ADDR_FIXED, addrS}); // [RULE_16] [RULE_17] [RULE_19]
  assign slotNext = (slotQ == IOX_SLOT_ACK) ? IOX_SLOT_FIRST : slotQ + 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Bus state machine

  always_ff @(posedge clk) begin
    if (rst) begin
      stateQ <= IOX_IDLE; // [RULE_01]
      slotQ <= IOX_SLOT_ACK;
      addrRwQ <= 1'b0;
    end else if (startCond) begin
      // Also covers a repeated start
      stateQ <= IOX_ADDR;
      slotQ <= IOX_SLOT_ACK;
    end else if (stopCond) begin
      stateQ <= IOX_IDLE;
    end else begin
      if (sclFall) begin
        slotQ <= slotNext;
      end
      case (stateQ)
        IOX_ADDR: begin
          if (byteDone) begin
            addrRwQ <= sclShiftQ[0];
            if (!addrMatch) begin
              stateQ <= IOX_OTHER; // [RULE_10]
            end else if (sclShiftQ[0]) begin
              stateQ <= IOX_RDATA; // [RULE_23]
            end else begin
              stateQ <= IOX_CMD; // [RULE_23]
            end
          end
        end
        IOX_CMD: begin
          if (byteDone) begin
            stateQ <= IOX_WDATA;
          end
        end
        IOX_RDATA: begin
          // Master not-acknowledge ends our transmission
          if (ackDone && sclShiftQ[0]) begin
            stateQ <= IOX_IGNORE; // [RULE_22]
          end
        end
        IOX_OTHER: begin
          if (ackDone) begin
            stateQ <= IOX_IGNORE;
          end
        end
        default: begin
          stateQ <= stateQ;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] cmdQ;
  logic [7:0] outQ;
  logic [7:0] polQ;
  logic [7:0] cfgQ;
  logic [7:0] inputView;
  logic [7:0] readValue;

  always_ff @(posedge clk) begin
    if (rst) begin
      cmdQ <= IOX_CMD_RST; // [RULE_01]
      outQ <= IOX_OUT_RST; // [RULE_26]
      polQ <= IOX_POL_RST; // [RULE_25]
      cfgQ <= IOX_CFG_RST; // [RULE_02] [RULE_26]
    end else if (byteDone && stateQ == IOX_CMD) begin
      cmdQ <= sclShiftQ; // [RULE_24]
    end else if (byteDone && stateQ == IOX_WDATA) begin
      // Pointer stays; every further byte goes to the same register
      case (cmdQ[1:0])
        IOX_REG_OUTPUT: outQ <= sclShiftQ;
        IOX_REG_POLARITY: polQ <= sclShiftQ;
        IOX_REG_CONFIG: cfgQ <= sclShiftQ;
        default: outQ <= outQ;
      endcase
    end
  end

  assign inputView = pinS ^ (polQ & cfgQ); // [RULE_25]

  always_comb begin
    case (cmdQ[1:0])
      IOX_REG_INPUT: readValue = inputView;
      IOX_REG_OUTPUT: readValue = outQ;
      IOX_REG_POLARITY: readValue = polQ;
      default: readValue = cfgQ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // SDA drive, changed on SCL falling and released at start or stop

  logic sdaOeQ;
  logic [7:0] txQ;

  always_ff @(posedge clk) begin
    if (rst || startCond || stopCond) begin
      ackNextQ <= 1'b0;
    end else if (byteDone && ((stateQ == IOX_ADDR && addrMatch) || stateQ == IOX_CMD || stateQ == IOX_WDATA)) begin
      ackNextQ <= 1'b1; // [RULE_18] [RULE_22]
    end else if (sclFall && slotNext == IOX_SLOT_ACK) begin
      ackNextQ <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || startCond || stopCond) begin
      sdaOeQ <= 1'b0;
      txQ <= '0;
    end else if (sclFall) begin
      if (slotNext == IOX_SLOT_ACK) begin
        sdaOeQ <= ackNextQ; // [RULE_18] [RULE_21]
      end else if (stateQ == IOX_RDATA) begin
        // Open drain: enable only for zero bits, MSB first
        if (slotNext == IOX_SLOT_FIRST) begin
          sdaOeQ <= !readValue[7];
          txQ <= {readValue[6:0], 1'b0};
        end else begin
          sdaOeQ <= !txQ[7];
          txQ <= {txQ[6:0], 1'b0};
        end
      end else begin
        sdaOeQ <= 1'b0; // [RULE_10] [RULE_22]
      end
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOe = sdaOeQ;

  ////////////////////////////////////////////////////////////////////////////
  // Change alert

  logic readClear;
  logic errClear;
  logic clearNow;
  logic [1:0] initQ;
  logic armedQ;
  logic [7:0] refQ;
  logic [7:0] mismatch;
  logic alertQ;

  assign readClear = ackDone && stateQ == IOX_RDATA && cmdQ[1:0] == IOX_REG_INPUT; // [RULE_06] [RULE_07]
  // Defect kept: a foreign read address acked while pointer is 00h clears
  assign errClear = ackDone && stateQ == IOX_OTHER && addrRwQ && !sclShiftQ[0]
    && cmdQ == IOX_CMD_ERRATUM; // [RULE_13] [RULE_14]
  assign clearNow = readClear || errClear;
  // Output pins are masked out
  assign mismatch = (pinS ^ refQ) & cfgQ; // [RULE_10] [RULE_11] [RULE_27]

  always_ff @(posedge clk) begin
    if (rst) begin
      initQ <= 2'h0;
    end else if (initQ != IOX_INIT_DONE) begin
      initQ <= initQ + 2'h1;
    end
  end

  // Reference taken when synchronisers are valid and at each clear
  always_ff @(posedge clk) begin
    if (rst) begin
      armedQ <= 1'b0;
      refQ <= '0;
    end else if ((initQ == IOX_INIT_DONE && !armedQ) || clearNow) begin
      armedQ <= 1'b1;
      refQ <= pinS; // [RULE_06] [RULE_08] [RULE_09] [RULE_27]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      alertQ <= 1'b0;
    end else begin
      alertQ <= armedQ && (|mismatch); // [RULE_05] [RULE_06]
    end
  end

  assign changeAlertNOut = 1'b0; // [RULE_12]
  assign changeAlertNOe = alertQ;

  ////////////////////////////////////////////////////////////////////////////
  // Port pin drive

  assign portPinsDrive.level = outQ; // [RULE_04]
  assign portPinsDrive.enable = ~cfgQ; // [RULE_03] [RULE_26]
  assign portDrivers.highSideDriver = ~cfgQ & outQ; // [RULE_04]
  assign portDrivers.lowSideDriver = ~cfgQ & ~outQ; // [RULE_04]

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence ackSlotS;
    sclFall && ackNextQ && slotNext == IOX_SLOT_ACK;
  endsequence

  sequence inputReadAckS;
    readClear;
  endsequence

  reset_state_a: assert property ($fell(rst) |-> stateQ == IOX_IDLE && !sdaOeQ && !alertQ) // [RULE_01]
    else $error("bus machine not idle after reset");

  reset_inputs_a: assert property ($fell(rst) |-> portPinsDrive.enable == 8'h00 && polQ == IOX_POL_RST) // [RULE_02]
    else $error("pins not inputs after reset");

  input_hiz_a: assert property (((portDrivers.highSideDriver | portDrivers.lowSideDriver) & cfgQ) == 8'h00) // [RULE_03]
    else $error("driver active on input pin");

  out_follow_a: assert property ((portDrivers.highSideDriver & ~portPinsDrive.level) == 8'h00 // [RULE_04]
    && (portDrivers.lowSideDriver & portPinsDrive.level) == 8'h00)
    else $error("output driver disagrees with level");

  alert_raise_a: assert property (armedQ && (|mismatch) |-> ##[1:AlertBound] changeAlertNOe) // [RULE_05]
    else $error("alert not raised after input change");

  read_clear_a: assert property (inputReadAckS ##1 !(|mismatch) |=> !changeAlertNOe) // [RULE_06]
    else $error("alert not cleared by input read");

  realert_a: assert property (clearNow |=> armedQ && refQ == $past(pinS)) // [RULE_09]
    else $error("clear did not rearm change detection");

  // Output pins differ from the reference while input pins match
  output_quiet_a: assert property ((|((pinS ^ refQ) & ~cfgQ)) && ((pinS ^ refQ) & cfgQ) == 8'h00 // [RULE_10]
    |=> !changeAlertNOe)
    else $error("output pin raised alert");

  foreign_quiet_a: assert property ((stateQ == IOX_OTHER || stateQ == IOX_IGNORE) |-> !sdaOeQ) // [RULE_10]
    else $error("SDA driven for foreign traffic");

  alert_od_a: assert property (changeAlertNOe |-> !changeAlertNOut) // [RULE_12]
    else $error("alert drives high");

  erratum_a: assert property (errClear |=> refQ == $past(pinS)) // [RULE_13]
    else $error("foreign read ack did not reload reference");

  addr_ack_a: assert property (ackSlotS |=> sdaOeQ && slotQ == IOX_SLOT_ACK) // [RULE_18]
    else $error("ack not driven in ack slot");

  addr_dir_a: assert property (byteDone && stateQ == IOX_ADDR && addrMatch && !startCond && !stopCond // [RULE_23]
    |=> stateQ == ($past(sclShiftQ[0]) ? IOX_RDATA : IOX_CMD))
    else $error("address byte mis-decoded");

  pointer_a: assert property (byteDone && stateQ == IOX_CMD && !startCond && !stopCond // [RULE_24]
    |=> cmdQ == $past(sclShiftQ))
    else $error("command byte not stored");

  release_a: assert property (sclFall && slotQ == IOX_SLOT_ACK && stateQ != IOX_RDATA // [RULE_21]
    && !startCond && !stopCond |=> !sdaOeQ)
    else $error("SDA not released after ack");

endmodule

// ===== iox_pkg.sv
// Constants and types shared by the eight-bit serial-bus port expander
package iox_pkg;

  localparam int IOX_WIDTH = 8;

  // Fixed upper nibble of the bus address
  localparam logic [3:0] IOX_ADDR_FIXED = 4'h4;

  // Register select, low two bits of the command byte
  localparam logic [1:0] IOX_REG_INPUT = 2'h0;
  localparam logic [1:0] IOX_REG_OUTPUT = 2'h1;
  localparam logic [1:0] IOX_REG_POLARITY = 2'h2;
  localparam logic [1:0] IOX_REG_CONFIG = 2'h3;

  // Reset values
  localparam logic [7:0] IOX_CMD_RST = 8'h00;
  localparam logic [7:0] IOX_OUT_RST = 8'hff;
  localparam logic [7:0] IOX_POL_RST = 8'h00;
  localparam logic [7:0] IOX_CFG_RST = 8'hff;

  // Command byte value that triggers the faulty alert clear
  localparam logic [7:0] IOX_CMD_ERRATUM = 8'h00;

  // Bit slots within a nine-clock byte frame
  localparam logic [3:0] IOX_SLOT_FIRST = 4'h0;
  localparam logic [3:0] IOX_SLOT_LAST_DATA = 4'h7;
  localparam logic [3:0] IOX_SLOT_ACK = 4'h8;

  // Cycles after reset release before the pin reference is taken
  localparam logic [1:0] IOX_INIT_DONE = 2'h3;

  // Timing
  localparam int IOX_CLK_PERIOD_NS = 5;
  localparam int IOX_ALERT_VALID_DELAY_NS = 4000;
  localparam int IOX_ALERT_VALID_CYC = IOX_ALERT_VALID_DELAY_NS / IOX_CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    IOX_IDLE,
    IOX_ADDR,
    IOX_CMD,
    IOX_WDATA,
    IOX_RDATA,
    IOX_OTHER,
    IOX_IGNORE
  } iox_state_t;

  // Drive of the eight port pins
  typedef struct packed {
    logic [IOX_WIDTH-1:0] level;
    logic [IOX_WIDTH-1:0] enable;
  } iox_drive_t;

  // Per-pin output transistor controls
  typedef struct packed {
    logic [IOX_WIDTH-1:0] highSideDriver;
    logic [IOX_WIDTH-1:0] lowSideDriver;
  } iox_side_t;

endpackage

// ===== iox_master.sv
// Serial-bus master model that drives the expander link
`timescale 1ns/1ps
module iox_master (
  output logic scl,
  output logic sdaLow,
  input wire logic sda
);
  // SCL stands high between frames; each phase lasts 128 ns
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic start();
    #32;
    sdaLow = 1'b0;
    #96;
    scl = 1'b1;
    #128;
    sdaLow = 1'b1;
    #128;
    scl = 1'b0;
  endtask

  task automatic stop();
    #32;
    sdaLow = 1'b1;
    #96;
    scl = 1'b1;
    #128;
    sdaLow = 1'b0;
    #128;
  endtask

  // Data set well after SCL falls, sampled in mid high phase
  task automatic bitx(input logic b, output logic s);
    #32;
    sdaLow = ~b;
    #96;
    scl = 1'b1;
    #64;
    s = sda;
    #64;
    scl = 1'b0;
  endtask

  task automatic xfer(input logic [7:0] w, input logic ackIn, output logic [7:0] r, output logic ackOut);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bitx(w[i], b);
      r[i] = b;
    end
    bitx(ackIn, ackOut);
  endtask
endmodule

// ===== iox_expander_test.sv
// Self-checking bench for the serial-bus port expander
`timescale 1ns/1ps
module iox_expander_test;
  import iox_pkg::*;
  logic clk;
  logic rst;
  logic [7:0] pinsExt;
  logic [2:0] addrSel;
  logic scl;
  logic sdaLow;
  logic sda;
  logic sdaOut;
  logic sdaOe;
  logic alertOut;
  logic alertOe;
  logic [7:0] pins;
  iox_drive_t drive;
  iox_side_t side;
  logic [7:0] rdData;
  logic ack;
  int error_cnt = 0;
  int n_checks = 0;
  int cycles = 0;

  // Pulled-up SDA; pins show the driver where enabled
  assign sda = ~(sdaLow | sdaOe);
  assign pins = (drive.enable & drive.level) | (~drive.enable & pinsExt);

  iox_expander dut (.clk(clk), .rst(rst), .sclClk(scl), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addrSelectBit0(addrSel[0]), .addrSelectBit1(addrSel[1]), .addrSelectBit2(addrSel[2]), .portPinsIn(pins),
    .portPinsDrive(drive), .portDrivers(side), .changeAlertNOut(alertOut), .changeAlertNOe(alertOe));
  iox_master m (.scl(scl), .sdaLow(sdaLow), .sda(sda));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      error_cnt++;
      $display("Error cycle limit expected 80000 seen %0d", cycles);
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    m.start();
    m.xfer({IOX_ADDR_FIXED, addrSel, 1'b0}, 1'b1, rdData, ack);
    chk("addr ack", 16'h0, {15'h0, ack});
    m.xfer(cmd, 1'b1, rdData, ack);
    chk("cmd ack", 16'h0, {15'h0, ack});
    m.xfer(d, 1'b1, rdData, ack);
    chk("data ack", 16'h0, {15'h0, ack});
    m.stop();
  endtask

  task automatic rd(input logic [7:0] cmd, input logic [7:0] exp, input string name);
    m.start();
    m.xfer({IOX_ADDR_FIXED, addrSel, 1'b0}, 1'b1, rdData, ack);
    m.xfer(cmd, 1'b1, rdData, ack);
    m.start();
    m.xfer({IOX_ADDR_FIXED, addrSel, 1'b1}, 1'b1, rdData, ack);
    chk("read addr ack", 16'h0, {15'h0, ack});
    m.xfer(8'hff, 1'b1, rdData, ack);
    m.stop();
    chk(name, {8'h0, exp}, {8'h0, rdData});
  endtask

  // Transfer to another address; ackIn low plays the other device
  task automatic other(input logic rw, input logic ackIn);
    m.start();
    m.xfer({IOX_ADDR_FIXED, ~addrSel, rw}, ackIn, rdData, ack);
    m.stop();
  endtask

  task automatic waitAlert(input logic exp, input logic quiet);
    if (quiet) begin
      repeat (20) @(negedge clk);
    end
    for (int i = 0; i < 20 && alertOe !== exp; i++) begin
      @(negedge clk);
    end
    chk("alert", {15'h0, exp}, {15'h0, alertOe});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("sda drive", 16'h0, {15'h0, sdaOe});
    chk("sda out", 16'h0, {15'h0, sdaOut});
    chk("alert", 16'h0, {15'h0, alertOe});
    chk("pin drive", 16'hff00, drive);
    chk("drivers", 16'h0, side);
    rd(8'h01, 8'hff, "output reg");
    rd(8'h02, 8'h00, "polarity reg");
    rd(8'h03, 8'hff, "config reg");
    $display("test reset done");
  endtask

  task automatic t_output();
    wr(8'h01, 8'h55);
    wr(8'h03, 8'h0f);
    @(negedge clk);
    chk("pin drive", 16'h55f0, drive);
    chk("drivers", 16'h50a0, side);
    waitAlert(1'b0, 1'b1);
    wr(8'h00, 8'haa);
    rd(8'h01, 8'h55, "output reg");
    rd(8'h03, 8'h0f, "config reg");
    $display("test output done");
  endtask

  task automatic t_alert();
    @(negedge clk) pinsExt = 8'h01;
    waitAlert(1'b1, 1'b0);
    chk("alert out", 16'h0, {15'h0, alertOut});
    @(negedge clk) pinsExt = 8'h00;
    waitAlert(1'b0, 1'b0);
    @(negedge clk) pinsExt = 8'h82;
    waitAlert(1'b1, 1'b0);
    rd(8'h00, 8'h52, "input reg");
    waitAlert(1'b0, 1'b1);
    $display("test alert done");
  endtask

  task automatic t_polarity();
    wr(8'h02, 8'h83);
    rd(8'h00, 8'h51, "inverted input");
    wr(8'h03, 8'h8f);
    waitAlert(1'b1, 1'b0);
    rd(8'h00, 8'h51, "input after switch");
    waitAlert(1'b0, 1'b1);
    $display("test polarity done");
  endtask

  task automatic t_foreign();
    other(1'b0, 1'b1);
    chk("foreign ack", 16'h1, {15'h0, ack});
    @(negedge clk) pinsExt = 8'h83;
    waitAlert(1'b1, 1'b0);
    other(1'b1, 1'b0);
    waitAlert(1'b0, 1'b0);
    wr(8'h01, 8'h55);
    @(negedge clk) pinsExt = 8'h82;
    waitAlert(1'b1, 1'b0);
    other(1'b1, 1'b0);
    waitAlert(1'b1, 1'b1);
    $display("test foreign done");
  endtask

  initial begin
    rst = 1'b1;
    pinsExt = 8'h00;
    addrSel = 3'h5;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
    t_reset();
    t_output();
    t_alert();
    t_polarity();
    t_foreign();
    end_of_test();
  end
endmodule
